// [verilog/sarcs_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module sarcs_ctrl (
  input  wire logic                        mclk,
  input  wire logic                        srst,
  input  wire logic                        supply_low,
  input  wire logic                        conversion_start_input,
  input  wire logic                        compare_in,
  input  wire logic                        output_en_n,
  output logic                             busy,
  output logic                             core_power_on,
  output logic                             ready,
  output logic                             result_valid,
  output logic                             result_top_bit,
  output logic                             result_top_bit_oe_n,
  output logic [sarcs_pkg::RES_W-1:0]      result
);
  import sarcs_pkg::*;

  // Two-stage synchronisers for pins, three stages for the start pin
  logic [2:0] cnv_sync_reg;
  logic [1:0] sup_sync_reg;
  logic [1:0] cmp_sync_reg;
  logic [1:0] oen_sync_reg;
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnv_sync_reg <= 3'h0;
      sup_sync_reg <= 2'h3;
      cmp_sync_reg <= 2'h0;
      oen_sync_reg <= 2'h3;
    end else begin
      cnv_sync_reg <= {cnv_sync_reg[1:0], conversion_start_input};
      sup_sync_reg <= {sup_sync_reg[0], supply_low};
      cmp_sync_reg <= {cmp_sync_reg[0], compare_in};
      oen_sync_reg <= {oen_sync_reg[0], output_en_n};
    end
  end

  // Edge looks only at stages two and three
  wire start_edge = cnv_sync_reg[1] & ~cnv_sync_reg[2];
  wire supply_dip = sup_sync_reg[1];

  sarcs_state_e      state_reg, state_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic [4:0]        step_reg, step_next;
  logic [RES_W-1:0]  sar_reg, sar_next;
  logic              stale_reg, stale_next;

  wire conv_done  = (state_reg == SARCS_CONV) && (cnt_reg == CNT_W'(CONV_CYC - 1));
  wire init_done  = (state_reg == SARCS_INIT) && (cnt_reg == CNT_W'(REINIT_CYC - 1));
  // One SAR decision per cycle, spread over the first 18 cycles
  wire step_live  = (state_reg == SARCS_CONV) && (step_reg <= STEP_LAST);
  wire [4:0] bit_idx = 5'(STEP_LAST - step_reg);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + CNT_W'(1);
    step_next  = step_reg;
    sar_next   = sar_reg;
    stale_next = stale_reg;
    case (state_reg)
      SARCS_INIT: begin
        if (init_done) state_next = SARCS_IDLE;
        if (start_edge) stale_next = 1'b1;
      end
      SARCS_IDLE: begin
        cnt_next = '0;
        if (start_edge) begin
          state_next = SARCS_CONV;
          step_next  = STEP_RST;
          sar_next   = '0;
        end
      end
      SARCS_CONV: begin
        // Further edges ignored while converting
        if (step_live) begin
          sar_next[bit_idx] = cmp_sync_reg[1];
          step_next = step_reg + 5'h01;
        end
        if (conv_done) begin
          state_next = SARCS_IDLE;
          cnt_next   = '0;
          stale_next = 1'b0;
        end
      end
      default: state_next = SARCS_INIT;
    endcase
    if (supply_dip) begin
      state_next = SARCS_INIT;
      cnt_next   = '0;
      stale_next = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= SARCS_INIT;
      cnt_reg   <= '0;
      step_reg  <= STEP_RST;
      sar_reg   <= '0;
      stale_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      step_reg  <= step_next;
      sar_reg   <= sar_next;
      stale_reg <= stale_next;
    end
  end

  // Completion captures result; early starts spoil validity of the next completed conversion only
  logic [RES_W-1:0] res_q;
  sarcs_result_reg u_res (
    .mclk (mclk),
    .srst (srst),
    .load (conv_done),
    .din  (sar_next),
    .dout (res_q)
  );
  assign result = res_q;

  wire conv_next = (state_next == SARCS_CONV);
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy                <= 1'b0;
      core_power_on       <= 1'b0;
      ready               <= 1'b0;
      result_valid        <= 1'b0;
      result_top_bit      <= 1'b0;
      result_top_bit_oe_n <= 1'b1;
    end else begin
      busy          <= conv_next;
      core_power_on <= conv_next;
      ready         <= (state_next == SARCS_IDLE);
      if (conv_done) begin
        result_valid   <= ~stale_reg;
        result_top_bit <= sar_next[RES_W-1];
      end else if (state_next == SARCS_INIT) begin
        result_valid <= 1'b0;
      end
      result_top_bit_oe_n <= oen_sync_reg[1];
    end
  end

  // Sequences shared by the checks below
  sequence conv_start_s;
    (state_reg == SARCS_IDLE) && start_edge && !supply_dip;
  endsequence

  sequence conv_end_s;
    conv_done && !supply_dip;
  endsequence

  sequence init_start_s;
    (state_reg == SARCS_INIT) && start_edge && !supply_dip;
  endsequence

  // Start of a conversion
  busy_rise_a: assert property (@(posedge mclk) disable iff (srst)
    conv_start_s |=> busy)
    else $error("busy did not rise");
  busy_hold_a: assert property (@(posedge mclk) disable iff (srst)
    conv_start_s |=> busy [*8])
    else $error("busy dropped early");
  core_on_a: assert property (@(posedge mclk) disable iff (srst)
    conv_start_s |=> core_power_on)
    else $error("core not powered");
  // Early starts only spoil the next result, they never convert
  init_block_a: assert property (@(posedge mclk) disable iff (srst)
    init_start_s |=> !busy && stale_reg)
    else $error("start taken during init");

  // While converting
  no_restart_a: assert property (@(posedge mclk) disable iff (srst)
    (state_reg == SARCS_CONV) && start_edge && !conv_done && !supply_dip
      |=> $stable(step_reg) || step_reg == $past(step_reg) + 5'h01)
    else $error("conversion restarted");
  ready_busy_a: assert property (@(posedge mclk) disable iff (srst)
    !(ready && busy))
    else $error("ready while busy");
  // Edge is seen one cycle before busy rises, so the low level lands on 31
  conv_bound_a: assert property (@(posedge mclk) disable iff (srst)
    conv_start_s |-> ##[1:31] !busy)
    else $error("conversion too long");

  // End of a conversion
  busy_fall_a: assert property (@(posedge mclk) disable iff (srst)
    conv_end_s |=> $fell(busy) && ready)
    else $error("busy did not fall");
  core_off_a: assert property (@(posedge mclk) disable iff (srst)
    conv_end_s |=> !core_power_on)
    else $error("core left on");
  core_busy_a: assert property (@(posedge mclk) disable iff (srst)
    core_power_on == busy)
    else $error("core and busy differ");
  top_bit_a: assert property (@(posedge mclk) disable iff (srst)
    $fell(busy) && !$past(supply_dip) |-> result_top_bit == result[RES_W-1])
    else $error("top bit mismatch");
  // Enable is only resynchronised, so it trails the pin by a fixed lag
  oe_follow_a: assert property (@(posedge mclk) disable iff (srst)
    !$past(srst) |-> result_top_bit_oe_n == $past(oen_sync_reg[1]))
    else $error("output enable lag");

  // Result validity
  valid_stale_a: assert property (@(posedge mclk) disable iff (srst)
    conv_done && stale_reg |=> !result_valid)
    else $error("stale result valid");
  valid_clean_a: assert property (@(posedge mclk) disable iff (srst)
    conv_done && !stale_reg |=> result_valid)
    else $error("clean result invalid");
  stale_clear_a: assert property (@(posedge mclk) disable iff (srst)
    conv_end_s |=> !stale_reg)
    else $error("stale mark kept");

  // Supply monitor
  dip_reset_a: assert property (@(posedge mclk) disable iff (srst)
    supply_dip |=> !busy && !ready)
    else $error("dip not handled");
  reinit_a: assert property (@(posedge mclk) disable iff (srst)
    $rose(ready) |-> $past(state_reg) == SARCS_INIT || $past(busy))
    else $error("ready without init");
endmodule : sarcs_ctrl
`default_nettype wire

// [verilog/sarcs_pkg.sv]
// Notes on behaviour
// - Power-on reset is held at power-up and whenever the supply monitor reports a dip.
// - After the supply returns, a re-initialisation interval runs before results count.
// - A rising start edge powers up the core and begins a conversion.
// - Start edges during a running conversion are ignored.
// - Busy stays high for the whole conversion.
// - After completion the core powers down until the next start edge.
// - Busy rises at conversion start and falls as soon as it finishes.
// - A conversion completes within 1.5 us of its start edge; the code lets busy fall 31 cycles (1.55 us) after the edge is detected.
// - With output enabled, the result top bit is presented when busy falls.
package sarcs_pkg;
  localparam int unsigned CLK_HZ         = 20000000;
  localparam int unsigned REINIT_US      = 200;
  localparam int unsigned CONV_MAX_NS    = 1500;
  localparam int unsigned RES_W          = 18;
  localparam int unsigned REINIT_CYC     = (REINIT_US * (CLK_HZ / 1000000));
  localparam int unsigned CONV_CYC       = (CONV_MAX_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned CNT_W          = 13;
  localparam logic [4:0]  STEP_LAST      = 5'h11;
  localparam logic [4:0]  STEP_RST       = 5'h00;
  typedef enum logic [1:0] {SARCS_INIT, SARCS_IDLE, SARCS_CONV} sarcs_state_e;
endpackage : sarcs_pkg

// [verilog/sarcs_result_reg.sv]
`timescale 1ns/1ps
`default_nettype none
module sarcs_result_reg (
  input  wire logic                          mclk,
  input  wire logic                          srst,
  input  wire logic                          load,
  input  wire logic [sarcs_pkg::RES_W-1:0]   din,
  output logic      [sarcs_pkg::RES_W-1:0]   dout
);
  import sarcs_pkg::*;
  always_ff @(posedge mclk) begin
    if (srst) dout <= '0;
    else if (load) dout <= din;
  end
endmodule : sarcs_result_reg
`default_nettype wire

// [testbench/sarcs_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sarcs_host_model (
  input  wire logic mclk,
  input  wire logic busy,
  output logic      conversion_start_input,
  output logic      compare_in
);
  initial begin
    conversion_start_input = 1'b0;
    compare_in = 1'b0;
  end
  // One conversion; extra toggles stay inside the short window after the rise
  task automatic convert(input logic bv, input logic extra, output int width);
    int n;
    n = 0;
    @(posedge mclk);
    #5 conversion_start_input = 1'b1;
    compare_in = bv;
    if (extra) begin
      #15 conversion_start_input = 1'b0;
      #15 conversion_start_input = 1'b1;
    end
    while (busy !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #5 n++;
    end
    width = 0;
    while (busy === 1'b1 && width < 60) begin
      @(posedge mclk);
      #5 width++;
    end
    conversion_start_input = 1'b0;
    // Stale comparator level is inverted, never left at the last value
    compare_in = ~bv;
  endtask : convert
endmodule : sarcs_host_model
`default_nettype wire

// [testbench/tb_sar_conversion_start_control.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_sar_conversion_start_control;
  import sarcs_pkg::*;
  logic             mclk = 0, srst = 1, supply_low = 0, output_en_n = 1;
  wire logic        start, cmp;
  logic             busy, core, ready, valid, top, oe_n, b, e;
  logic [RES_W-1:0] result;
  int               mismatches = 0, checks_done = 0, cycles = 0, w;
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  sarcs_ctrl u_dut (.mclk(mclk), .srst(srst), .supply_low(supply_low),
    .conversion_start_input(start), .compare_in(cmp), .output_en_n(output_en_n),
    .busy(busy), .core_power_on(core), .ready(ready), .result_valid(valid),
    .result_top_bit(top), .result_top_bit_oe_n(oe_n), .result(result));
  sarcs_host_model u_host (.mclk(mclk), .busy(busy), .conversion_start_input(start),
    .compare_in(cmp));
  task chk(input string what, input logic [RES_W-1:0] exp, input logic [RES_W-1:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function logic [RES_W-1:0] fill(input logic bv);
    return {RES_W{bv}};
  endfunction : fill
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task wait_ready;
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 5000) begin
      @(posedge mclk);
      #5 n++;
    end
    chk("ready", 1, ready);
  endtask : wait_ready
  task run(input logic bv, input logic extra, input logic ev);
    u_host.convert(bv, extra, w);
    chk("busy_width", CONV_CYC, w);
    chk("core_power", 0, core);
    chk("result", fill(bv), result);
    chk("top_bit", bv, top);
    chk("valid", ev, valid);
  endtask : run
  initial begin
    b = $urandom(32'h30AD7676);
    repeat (3) @(posedge mclk);
    #5 srst = 0;
    // Start during re-initialisation must not convert
    u_host.convert(1'b1, 1'b0, w);
    chk("early_width", 0, w);
    wait_ready();
    run(1'b1, 1'b0, 1'b0);
    repeat (6) begin
      b = $urandom % 2;
      e = $urandom % 2;
      output_en_n = e;
      run(b, $urandom % 2, 1'b1);
      chk("oe_n", e, oe_n);
    end
    supply_low = 1;
    repeat (5) @(posedge mclk);
    #5 chk("ready_dip", 0, ready);
    supply_low = 0;
    wait_ready();
    run(1'b0, 1'b1, 1'b1);
    wrap_up();
  end
endmodule : tb_sar_conversion_start_control
`default_nettype wire
